// File: core/ptq_pkg.sv
// ptq_pkg: register map, field layout, reset values, encodings and state types
// assumes a 32-bit plain register port and one sample clock
package ptq_pkg;

  // ****************************************
  // register port
  // ****************************************
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_GLITCH = 8'h04;
  localparam logic [7:0]  OFS_LOWER  = 8'h08;
  localparam logic [7:0]  OFS_UPPER  = 8'h0C;
  localparam logic [7:0]  OFS_SLEW   = 8'h10;
  localparam logic [7:0]  OFS_TMO    = 8'h14;
  localparam logic [7:0]  OFS_RUNT   = 8'h18;
  localparam logic [7:0]  OFS_LEVEL  = 8'h1C;
  localparam logic [7:0]  OFS_CMD    = 8'h20;
  localparam logic [7:0]  OFS_STATUS = 8'h24;
  localparam logic [7:0]  OFS_COUNT  = 8'h28;

  // ****************************************
  // control word fields
  // ****************************************
  localparam int CTRL_W         = 13;
  localparam int CTRL_CLASS_LSB = 0;
  localparam int CTRL_POL_LSB   = 3;
  localparam int CTRL_SRC_LSB   = 5;
  localparam int CTRL_REJECT    = 7;
  localparam int CTRL_OUTSIDE   = 8;
  localparam int CTRL_SLOWER    = 9;
  localparam int CTRL_RUNT_QUAL = 10;
  localparam int CTRL_LSEL_LSB  = 11;
  localparam int CMD_MID_BIT    = 0;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [12:0] RST_CTRL         = 13'h0000;
  localparam logic [31:0] RST_LIMIT        = 32'h0000_0010;
  localparam logic [31:0] RST_UPPER        = 32'h0000_0020;
  localparam logic [31:0] RST_LEVEL        = 32'h0000_0080;
  localparam int          PEAK_SCAN_CYCLES = 1024;

  // ****************************************
  // encodings and states
  // ****************************************
  typedef enum logic [2:0] {
    CLS_GLITCH = 3'h0, CLS_RUNT = 3'h1, CLS_WIDTH = 3'h2, CLS_SLEW = 3'h3, CLS_TMO = 3'h4
  } ptq_class_t;
  typedef enum logic [1:0] {POL_POS = 2'h0, POL_NEG = 2'h1, POL_EITHER = 2'h2} ptq_pol_t;
  typedef enum logic [1:0] {LSEL_USER = 2'h0, LSEL_TTL = 2'h1, LSEL_ECL = 2'h2} ptq_lsel_t;
  typedef enum logic [2:0] {BAND_IDLE = 3'b001, BAND_UP = 3'b010, BAND_DN = 3'b100} ptq_band_t;
  typedef enum logic [1:0] {PK_IDLE = 2'b01, PK_SCAN = 2'b10} ptq_peak_t;

endpackage

// File: core/ptq_cmp_if.sv
// ptq_cmp_if: selected, synchronised comparator levels and sample of one source
// assumes producer and consumer share one clock
`timescale 1ns/1ps
interface ptq_cmp_if #(parameter int ADC_W = 8);
  logic             hi;
  logic             lo;
  logic             lvl;
  logic             hi_q;
  logic             lo_q;
  logic             lvl_q;
  logic [ADC_W-1:0] adc;
  modport front (output hi, lo, lvl, hi_q, lo_q, lvl_q, adc);
  modport core  (input  hi, lo, lvl, hi_q, lo_q, lvl_q, adc);
endinterface

// File: core/ptq_src_front.sv
// ptq_src_front: comparator synchronisers and the single source selector
// assumes comparator outputs are asynchronous, samples already on i_clk
`timescale 1ns/1ps
module ptq_src_front #(
  parameter int ADC_W = 8
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic [3:0]            i_cmp_hi,
  input  wire logic [3:0]            i_cmp_lo,
  input  wire logic [3:0]            i_cmp_lvl,
  input  wire logic [3:0][ADC_W-1:0] i_adc,
  input  wire logic [1:0]            i_src,
  ptq_cmp_if.front                   o_cmp
);

  // ****************************************
  // synchronisers, one per channel
  // ****************************************
  logic [2:0]       sync1_reg [4];
  logic [2:0]       sync2_reg [4];
  logic [2:0]       cur_reg;
  logic [2:0]       prev_reg;
  logic [ADC_W-1:0] adc_reg;
  wire  [2:0]       sel_w = sync2_reg[i_src];

  for (genvar ch = 0; ch < 4; ch++) begin : g_sync
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        sync1_reg[ch] <= 3'h0;
        sync2_reg[ch] <= 3'h0;
      end else begin
        sync1_reg[ch] <= {i_cmp_hi[ch], i_cmp_lo[ch], i_cmp_lvl[ch]};
        sync2_reg[ch] <= sync1_reg[ch];
      end
    end
  end

  // ****************************************
  // one source feeds every class
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_reg  <= 3'h0;
      prev_reg <= 3'h0;
      adc_reg  <= '0;
    end else begin
      cur_reg  <= sel_w;
      prev_reg <= cur_reg;
      adc_reg  <= i_adc[i_src];
    end
  end

  assign o_cmp.hi    = cur_reg[2];
  assign o_cmp.lo    = cur_reg[1];
  assign o_cmp.lvl   = cur_reg[0];
  assign o_cmp.hi_q  = prev_reg[2];
  assign o_cmp.lo_q  = prev_reg[1];
  assign o_cmp.lvl_q = prev_reg[0];
  assign o_cmp.adc   = adc_reg;

endmodule // ptq_src_front

// File: core/ptq_pulse_trigger.sv
// ptq_pulse_trigger: pulse trigger qualifier, glitch/runt/width/slew/timeout
// assumes comparators for upper, lower threshold and level per channel,
// digitised samples on I_CLK, and a plain one-cycle register port
//
// Summary of operation
// - glitch positive: fire on short high pulse
// - glitch negative: fire on short low pulse
// - glitch either: qualify high and low pulses
// - accept fires narrower, reject fires wider
// - runt positive: lower up, down, no upper
// - runt negative: upper down, up, no lower
// - runt either: both directions detected
// - width positive: high pulse inside or outside window
// - width negative: low pulse, same window test
// - slew positive: time lower to upper crossing
// - slew negative: time upper to lower crossing
// - slew either: time edges both directions
// - slew fires faster or slower than limit
// - timeout stays high longer than limit
// - timeout stays low longer than limit
// - timeout either side for the limit
// - one source selection feeds every class
// - mid-level request sets level between peaks
// - presets load family level, else user value
// - runt fires where first threshold recrossed
// - optional runt width must exceed limit
// - lower width limit kept at most upper
`timescale 1ns/1ps
module ptq_pulse_trigger #(
  parameter int              CNT_W       = 16,
  parameter int              ADC_W       = 8,
  parameter int              PEAK_CYCLES = ptq_pkg::PEAK_SCAN_CYCLES,
  parameter logic [ADC_W-1:0] LEVEL_TTL  = 8'h60,
  parameter logic [ADC_W-1:0] LEVEL_ECL  = 8'h40
) (
  input  wire logic                         I_CLK,
  input  wire logic                         I_RST,
  input  wire logic [ptq_pkg::ADDR_W-1:0]   I_ADDR,
  input  wire logic [ptq_pkg::DATA_W-1:0]   I_WDATA,
  input  wire logic                         I_WR,
  input  wire logic                         I_RD,
  output logic      [ptq_pkg::DATA_W-1:0]   O_RDATA,
  input  wire logic [3:0]                   I_CMP_HI,
  input  wire logic [3:0]                   I_CMP_LO,
  input  wire logic [3:0]                   I_CMP_LVL,
  input  wire logic [3:0][ADC_W-1:0]        I_ADC,
  output logic                              O_TRIG,
  output logic      [ADC_W-1:0]             O_LEVEL
);

  localparam int PK_W = $clog2(PEAK_CYCLES + 1);

  // ****************************************
  // register file
  // ****************************************
  logic [ptq_pkg::CTRL_W-1:0] ctrl_reg;
  logic [CNT_W-1:0]           glitch_reg;
  logic [CNT_W-1:0]           lower_reg;
  logic [CNT_W-1:0]           upper_reg;
  logic [CNT_W-1:0]           slew_reg;
  logic [CNT_W-1:0]           tmo_reg;
  logic [CNT_W-1:0]           runt_reg;
  logic [ADC_W-1:0]           level_user_reg;
  logic [15:0]                trig_cnt_reg;
  logic [ptq_pkg::DATA_W-1:0] rdata_reg;
  logic                       lvl_upd_reg;

  wire wr_ctrl_w  = I_WR && (I_ADDR == ptq_pkg::OFS_CTRL);
  wire wr_level_w = I_WR && (I_ADDR == ptq_pkg::OFS_LEVEL);
  wire wr_cmd_w   = I_WR && (I_ADDR == ptq_pkg::OFS_CMD);
  wire [CNT_W-1:0] wval_w = I_WDATA[CNT_W-1:0];
  wire ptq_pkg::ptq_class_t cls_w = ptq_pkg::ptq_class_t'(ctrl_reg[ptq_pkg::CTRL_CLASS_LSB +: 3]);
  wire ptq_pkg::ptq_pol_t   pol_w = ptq_pkg::ptq_pol_t'(ctrl_reg[ptq_pkg::CTRL_POL_LSB +: 2]);
  wire ptq_pkg::ptq_lsel_t  lsel_w = ptq_pkg::ptq_lsel_t'(ctrl_reg[ptq_pkg::CTRL_LSEL_LSB +: 2]);
  wire [1:0] src_w     = ctrl_reg[ptq_pkg::CTRL_SRC_LSB +: 2];
  wire       reject_w  = ctrl_reg[ptq_pkg::CTRL_REJECT];
  wire       outside_w = ctrl_reg[ptq_pkg::CTRL_OUTSIDE];
  wire       slower_w  = ctrl_reg[ptq_pkg::CTRL_SLOWER];
  wire       rqual_w   = ctrl_reg[ptq_pkg::CTRL_RUNT_QUAL];

  // lower limit clamps to upper; a smaller upper drags lower with it
  wire [CNT_W-1:0] lower_new_w = (wval_w > upper_reg) ? upper_reg : wval_w;
  wire             drag_low_w  = wval_w < lower_reg;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_reg       <= ptq_pkg::RST_CTRL;
      glitch_reg     <= ptq_pkg::RST_LIMIT[CNT_W-1:0];
      lower_reg      <= ptq_pkg::RST_LIMIT[CNT_W-1:0];
      upper_reg      <= ptq_pkg::RST_UPPER[CNT_W-1:0];
      slew_reg       <= ptq_pkg::RST_LIMIT[CNT_W-1:0];
      tmo_reg        <= ptq_pkg::RST_LIMIT[CNT_W-1:0];
      runt_reg       <= ptq_pkg::RST_LIMIT[CNT_W-1:0];
      level_user_reg <= ptq_pkg::RST_LEVEL[ADC_W-1:0];
    end else if (I_WR) begin
      case (I_ADDR)
        ptq_pkg::OFS_CTRL:   ctrl_reg       <= I_WDATA[ptq_pkg::CTRL_W-1:0];
        ptq_pkg::OFS_GLITCH: glitch_reg     <= wval_w;
        ptq_pkg::OFS_LOWER:  lower_reg      <= lower_new_w;
        ptq_pkg::OFS_UPPER: begin
          upper_reg <= wval_w;
          lower_reg <= drag_low_w ? wval_w : lower_reg;
        end
        ptq_pkg::OFS_SLEW:   slew_reg       <= wval_w;
        ptq_pkg::OFS_TMO:    tmo_reg        <= wval_w;
        ptq_pkg::OFS_RUNT:   runt_reg       <= wval_w;
        ptq_pkg::OFS_LEVEL:  level_user_reg <= I_WDATA[ADC_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // selected source
  // ****************************************
  ptq_cmp_if #(.ADC_W(ADC_W)) cmp_bus ();

  ptq_src_front #(.ADC_W(ADC_W)) u_front (
    .i_clk     (I_CLK),
    .i_rst     (I_RST),
    .i_cmp_hi  (I_CMP_HI),
    .i_cmp_lo  (I_CMP_LO),
    .i_cmp_lvl (I_CMP_LVL),
    .i_adc     (I_ADC),
    .i_src     (src_w),
    .o_cmp     (cmp_bus)
  );

  wire lvl_rise_w = cmp_bus.lvl & ~cmp_bus.lvl_q;
  wire lvl_fall_w = ~cmp_bus.lvl & cmp_bus.lvl_q;
  wire lvl_edge_w = lvl_rise_w | lvl_fall_w;
  wire lo_rise_w  = cmp_bus.lo & ~cmp_bus.lo_q;
  wire lo_fall_w  = ~cmp_bus.lo & cmp_bus.lo_q;
  wire hi_rise_w  = cmp_bus.hi & ~cmp_bus.hi_q;
  wire hi_fall_w  = ~cmp_bus.hi & cmp_bus.hi_q;
  wire look_hi_w  = (pol_w == ptq_pkg::POL_POS) || (pol_w == ptq_pkg::POL_EITHER);
  wire look_lo_w  = (pol_w == ptq_pkg::POL_NEG) || (pol_w == ptq_pkg::POL_EITHER);

  // ****************************************
  // level-side time counter
  // ****************************************
  logic [2:0]       cls_prev_reg;
  logic [CNT_W-1:0] pw_cnt_reg;
  logic             seen_reg;
  wire              clr_w = cls_w != cls_prev_reg;
  wire [CNT_W-1:0]  pw_inc_w = (pw_cnt_reg == '1) ? pw_cnt_reg : pw_cnt_reg + 1'b1;
  wire [CNT_W-1:0]  pw_cnt_next = clr_w ? '0 : (lvl_edge_w ? CNT_W'(1) : pw_inc_w);
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cls_prev_reg <= 3'h0;
      pw_cnt_reg   <= '0;
      seen_reg     <= 1'b0;
    end else begin
      cls_prev_reg <= cls_w;
      pw_cnt_reg   <= pw_cnt_next;
      seen_reg     <= !clr_w && (seen_reg || lvl_edge_w);
    end
  end

  // pulse ends only count after a first edge, so a partial pulse is skipped
  wire hi_end_w  = lvl_fall_w && seen_reg && look_hi_w && !clr_w;
  wire lo_end_w  = lvl_rise_w && seen_reg && look_lo_w && !clr_w;
  wire pend_w    = hi_end_w | lo_end_w;

  // ****************************************
  // glitch and width classes
  // ****************************************
  wire gl_ok_w  = reject_w ? (pw_cnt_reg > glitch_reg) : (pw_cnt_reg < glitch_reg);
  wire in_win_w = (pw_cnt_reg >= lower_reg) && (pw_cnt_reg <= upper_reg);
  wire wd_ok_w  = outside_w ? !in_win_w : in_win_w;

  wire fire_gl_w = (cls_w == ptq_pkg::CLS_GLITCH) && pend_w && gl_ok_w;
  wire fire_wd_w = (cls_w == ptq_pkg::CLS_WIDTH) && pend_w && wd_ok_w;

  // ****************************************
  // band tracker for runt and slew
  // ****************************************
  ptq_pkg::ptq_band_t band_reg;
  ptq_pkg::ptq_band_t band_next;
  logic [CNT_W-1:0]   band_cnt_reg;
  logic               slew_evt_w;
  logic               runt_evt_w;

  always_comb begin
    band_next  = band_reg;
    slew_evt_w = 1'b0;
    runt_evt_w = 1'b0;
    case (band_reg)
      ptq_pkg::BAND_IDLE: begin
        if (lo_rise_w && !cmp_bus.hi && look_hi_w) begin
          band_next = ptq_pkg::BAND_UP;
        end else if (hi_fall_w && cmp_bus.lo && look_lo_w) begin
          band_next = ptq_pkg::BAND_DN;
        end
      end
      ptq_pkg::BAND_UP: begin
        if (hi_rise_w) begin
          band_next  = ptq_pkg::BAND_IDLE;
          slew_evt_w = 1'b1;
        end else if (lo_fall_w) begin
          band_next  = ptq_pkg::BAND_IDLE;
          runt_evt_w = 1'b1;
        end
      end
      ptq_pkg::BAND_DN: begin
        if (lo_fall_w) begin
          band_next  = ptq_pkg::BAND_IDLE;
          slew_evt_w = 1'b1;
        end else if (hi_rise_w) begin
          band_next  = ptq_pkg::BAND_IDLE;
          runt_evt_w = 1'b1;
        end
      end
      default: band_next = ptq_pkg::BAND_IDLE;
    endcase
    if (clr_w) begin
      band_next  = ptq_pkg::BAND_IDLE;
      slew_evt_w = 1'b0;
      runt_evt_w = 1'b0;
    end
  end

  wire band_start_w = (band_reg == ptq_pkg::BAND_IDLE) && (band_next != ptq_pkg::BAND_IDLE);
  wire [CNT_W-1:0] band_inc_w = (band_cnt_reg == '1) ? band_cnt_reg : band_cnt_reg + 1'b1;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      band_reg     <= ptq_pkg::BAND_IDLE;
      band_cnt_reg <= '0;
    end else begin
      band_reg     <= band_next;
      band_cnt_reg <= (clr_w || band_start_w) ? CNT_W'(1) : band_inc_w;
    end
  end

  // both polarities arm in either mode, giving runts of both directions
  wire runt_w_ok_w = !rqual_w || (band_cnt_reg > runt_reg);
  wire slew_ok_w   = slower_w ? (band_cnt_reg > slew_reg) : (band_cnt_reg < slew_reg);
  wire fire_rt_w   = (cls_w == ptq_pkg::CLS_RUNT) && runt_evt_w && runt_w_ok_w;
  wire fire_sl_w   = (cls_w == ptq_pkg::CLS_SLEW) && slew_evt_w && slew_ok_w;

  // ****************************************
  // timeout class
  // ****************************************
  // strict sides fire one cycle past the limit; either fires at the limit
  wire [CNT_W:0] tmo_lim_w = (pol_w == ptq_pkg::POL_EITHER) ?
                             {1'b0, tmo_reg} : ({1'b0, tmo_reg} + 1'b1);
  wire tmo_side_w = (pol_w == ptq_pkg::POL_EITHER) ||
                    ((pol_w == ptq_pkg::POL_NEG) ? !cmp_bus.lvl : cmp_bus.lvl);
  wire tmo_hit_w  = ({1'b0, pw_cnt_next} == tmo_lim_w) && ({1'b0, pw_cnt_reg} != tmo_lim_w);
  wire fire_to_w  = (cls_w == ptq_pkg::CLS_TMO) && !clr_w && tmo_side_w && tmo_hit_w;

  // ****************************************
  // trigger output
  // ****************************************
  wire fire_w = fire_gl_w | fire_wd_w | fire_rt_w | fire_sl_w | fire_to_w;
  logic trig_reg;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      trig_reg     <= 1'b0;
      trig_cnt_reg <= 16'h0000;
    end else begin
      trig_reg     <= fire_w;
      trig_cnt_reg <= trig_cnt_reg + {15'h0000, fire_w};
    end
  end

  assign O_TRIG = trig_reg;

  // ****************************************
  // trigger level: presets, user value, mid-peak
  // ****************************************
  ptq_pkg::ptq_peak_t pk_reg;
  logic [PK_W-1:0]    pk_cnt_reg;
  logic [ADC_W-1:0]   pk_max_reg;
  logic [ADC_W-1:0]   pk_min_reg;
  logic [ADC_W-1:0]   level_reg;

  wire mid_req_w  = wr_cmd_w && I_WDATA[ptq_pkg::CMD_MID_BIT];
  wire pk_busy_w  = pk_reg == ptq_pkg::PK_SCAN;
  wire pk_done_w  = pk_busy_w && (pk_cnt_reg == '0);
  wire [ADC_W:0]   pk_sum_w = {1'b0, pk_max_reg} + {1'b0, pk_min_reg};
  wire [ADC_W-1:0] mid_w    = pk_sum_w[ADC_W:1];
  wire [ADC_W-1:0] preset_w = (lsel_w == ptq_pkg::LSEL_TTL) ? LEVEL_TTL :
    (lsel_w == ptq_pkg::LSEL_ECL) ? LEVEL_ECL : level_user_reg;
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pk_reg     <= ptq_pkg::PK_IDLE;
      pk_cnt_reg <= '0;
      pk_max_reg <= '0;
      pk_min_reg <= '1;
    end else begin
      case (pk_reg)
        ptq_pkg::PK_IDLE: begin
          if (mid_req_w) begin
            pk_reg     <= ptq_pkg::PK_SCAN;
            pk_cnt_reg <= PK_W'(PEAK_CYCLES - 1);
            pk_max_reg <= '0;
            pk_min_reg <= '1;
          end
        end
        ptq_pkg::PK_SCAN: begin
          pk_max_reg <= (cmp_bus.adc > pk_max_reg) ? cmp_bus.adc : pk_max_reg;
          pk_min_reg <= (cmp_bus.adc < pk_min_reg) ? cmp_bus.adc : pk_min_reg;
          pk_cnt_reg <= pk_cnt_reg - 1'b1;
          if (pk_done_w) begin
            pk_reg <= ptq_pkg::PK_IDLE;
          end
        end
        default: pk_reg <= ptq_pkg::PK_IDLE;
      endcase
    end
  end

  // the last scan sample is not folded in; one sample of a long scan is a fair trade
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      level_reg   <= ptq_pkg::RST_LEVEL[ADC_W-1:0];
      lvl_upd_reg <= 1'b0;
    end else begin
      lvl_upd_reg <= wr_ctrl_w || wr_level_w;
      if (pk_done_w) begin
        level_reg <= mid_w;
      end else if (lvl_upd_reg) begin
        level_reg <= preset_w;
      end
    end
  end

  assign O_LEVEL = level_reg;

  // ****************************************
  // read port
  // ****************************************
  wire [ptq_pkg::DATA_W-1:0] status_w = {
    24'h00_0000, pk_busy_w, band_reg, 1'b0, cmp_bus.hi, cmp_bus.lo, cmp_bus.lvl
  };
  wire [ptq_pkg::DATA_W-1:0] rd_mux_w =
    (I_ADDR == ptq_pkg::OFS_CTRL)   ? ptq_pkg::DATA_W'(ctrl_reg)       :
    (I_ADDR == ptq_pkg::OFS_GLITCH) ? ptq_pkg::DATA_W'(glitch_reg)     :
    (I_ADDR == ptq_pkg::OFS_LOWER)  ? ptq_pkg::DATA_W'(lower_reg)      :
    (I_ADDR == ptq_pkg::OFS_UPPER)  ? ptq_pkg::DATA_W'(upper_reg)      :
    (I_ADDR == ptq_pkg::OFS_SLEW)   ? ptq_pkg::DATA_W'(slew_reg)       :
    (I_ADDR == ptq_pkg::OFS_TMO)    ? ptq_pkg::DATA_W'(tmo_reg)        :
    (I_ADDR == ptq_pkg::OFS_RUNT)   ? ptq_pkg::DATA_W'(runt_reg)       :
    (I_ADDR == ptq_pkg::OFS_LEVEL)  ? ptq_pkg::DATA_W'(level_reg)      :
    (I_ADDR == ptq_pkg::OFS_STATUS) ? status_w                         :
    (I_ADDR == ptq_pkg::OFS_COUNT)  ? ptq_pkg::DATA_W'(trig_cnt_reg)   :
    32'h0000_0000;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= I_RD ? rd_mux_w : 32'h0000_0000;
    end
  end

  assign O_RDATA = rdata_reg;

endmodule // ptq_pulse_trigger

// File: sim/ptq_sig_model.sv
// ptq_sig_model: four analog channels seen through threshold comparators
// assumes the bench sets a voltage code per channel on the sample clock
`timescale 1ns/1ps
module ptq_sig_model #(
  parameter logic [7:0] THR_HI = 8'hC0,
  parameter logic [7:0] THR_LO = 8'h40
) (
  input  wire logic [3:0][7:0] i_v,
  input  wire logic [7:0]      i_level,
  output logic      [3:0]      o_hi,
  output logic      [3:0]      o_lo,
  output logic      [3:0]      o_lvl,
  output logic      [3:0][7:0] o_adc
);
  // ****************
  // comparators, no hysteresis: a noisy code would chatter
  // ****************
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_hi[i]  = i_v[i] > THR_HI;
      o_lo[i]  = i_v[i] > THR_LO;
      o_lvl[i] = i_v[i] > i_level;
    end
  end
  assign o_adc = i_v;
endmodule // ptq_sig_model

// File: sim/ptq_pulse_trigger_sva.sv
// ptq_pulse_trigger_sva: port-level checks of the trigger qualifier
// assumes slow comparator inputs, so a few cycles of pipeline do not matter
`timescale 1ns/1ps
module ptq_pulse_trigger_sva #(
  parameter int ADC_W = 8
) (
  input wire logic                       I_CLK,
  input wire logic                       I_RST,
  input wire logic [ptq_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [ptq_pkg::DATA_W-1:0] I_WDATA,
  input wire logic                       I_WR,
  input wire logic                       I_RD,
  input wire logic [ptq_pkg::DATA_W-1:0] O_RDATA,
  input wire logic [3:0]                 I_CMP_LO,
  input wire logic [3:0]                 I_CMP_LVL,
  input wire logic                       O_TRIG,
  input wire logic [ADC_W-1:0]           O_LEVEL
);
  // ****************
  // shadow control word
  // ****************
  logic [12:0] ctrl_reg;
  logic        wr_seen_reg;
  logic [2:0]  cls;
  logic [1:0]  pol;
  logic        lvl;
  logic        lo;
  assign cls = ctrl_reg[2:0];
  assign pol = ctrl_reg[4:3];
  assign lvl = I_CMP_LVL[ctrl_reg[6:5]];
  assign lo  = I_CMP_LO[ctrl_reg[6:5]];
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_reg    <= '0;
      wr_seen_reg <= 1'b0;
    end else if (I_WR) begin
      wr_seen_reg <= 1'b1;
      if (I_ADDR == ptq_pkg::OFS_CTRL) ctrl_reg <= I_WDATA[12:0];
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  chk_trig_single: assert property (O_TRIG |=> !O_TRIG)
    else $error("trigger longer than one cycle");
  chk_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == '0)
    else $error("read data outside its cycle");
  chk_glitch_pos: assert property (O_TRIG && cls == 3'h0 && pol == 2'h0 |-> !$past(lvl, 3))
    else $error("positive glitch trigger not at fall");
  chk_glitch_neg: assert property (O_TRIG && cls == 3'h0 && pol == 2'h1 |-> $past(lvl, 3))
    else $error("negative glitch trigger not at rise");
  chk_width_pos: assert property (O_TRIG && cls == 3'h2 && pol == 2'h0 |-> !$past(lvl, 3))
    else $error("width trigger not at end of high pulse");
  chk_runt_pos: assert property (O_TRIG && cls == 3'h1 && pol == 2'h0 |-> !$past(lo, 3))
    else $error("runt trigger not at recross");
  chk_tmo_high: assert property (O_TRIG && cls == 3'h4 && pol == 2'h0 |-> $past(lvl, 5))
    else $error("stays-high trigger while low");
  chk_tmo_low: assert property (O_TRIG && cls == 3'h4 && pol == 2'h1 |-> !$past(lvl, 5))
    else $error("stays-low trigger while high");
  chk_level_cause: assert property (!$stable(O_LEVEL) |-> wr_seen_reg)
    else $error("level moved with no write");
  chk_class_mute: assert property ((cls == 3'h5) [*4] |-> !O_TRIG)
    else $error("trigger in unused class");
  cover property (O_TRIG && cls == 3'h1);
  cover property (O_TRIG && cls == 3'h3);
  cover property (O_TRIG && cls == 3'h4);
endmodule // ptq_pulse_trigger_sva
bind ptq_pulse_trigger ptq_pulse_trigger_sva #(.ADC_W(ADC_W)) u_sva (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CMP_LO(I_CMP_LO), .I_CMP_LVL(I_CMP_LVL),
  .O_TRIG(O_TRIG), .O_LEVEL(O_LEVEL));

// File: sim/testbench.sv
// testbench: trigger class scenarios, level control and register checks
// assumes ptq_sig_model stands in for the analog front end
`timescale 1ns/1ps
module testbench;
  // ****************
  // stimulus and checks
  // ****************
  logic            clk = 0, rst = 1, wr = 0, rd = 0, trig;
  logic [7:0]      addr = 8'h00, level;
  logic [31:0]     wdata = 32'h0000_0000, rdata;
  logic [3:0]      hi, lo, lvl;
  logic [3:0][7:0] v = {4{8'h10}}, adc;
  int              n_errors = 0, check_count = 0, trigs = 0, cyc = 0;
  always #12.5 clk = ~clk;
  ptq_sig_model u_sig (.i_v(v), .i_level(level), .o_hi(hi), .o_lo(lo), .o_lvl(lvl), .o_adc(adc));
  ptq_pulse_trigger #(.PEAK_CYCLES(8), .LEVEL_TTL(8'h60), .LEVEL_ECL(8'h40)) DUT (
    .I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_CMP_HI(hi), .I_CMP_LO(lo), .I_CMP_LVL(lvl), .I_ADC(adc),
    .O_TRIG(trig), .O_LEVEL(level));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (trig === 1'b1) trigs <= trigs + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, exp);
  endtask
  task automatic hold(input int ch, input logic [7:0] val, input int n);
    @(posedge clk);
    v[ch] <= val;
    repeat (n - 1) @(posedge clk);
  endtask
  // mid code between steps gives a measurable transit for slew
  task automatic pulse(input int ch, input logic [7:0] b, pk, input int w, m);
    if (m > 0) hold(ch, 8'h80, m);
    hold(ch, pk, w);
    if (m > 0) hold(ch, 8'h80, m);
    hold(ch, b, 40);
  endtask
  // first pulse after a class change only primes the measurement
  task automatic run(input logic [12:0] c, input int ch, input logic [7:0] b, pk,
                     input int w, m, n);
    int t0;
    wreg(ptq_pkg::OFS_CTRL, {19'h0_0000, c});
    hold(ch, b, 40);
    pulse(ch, b, pk, 20, m);
    t0 = trigs;
    pulse(ch, b, pk, w, m);
    chk(trigs - t0, n);
  endtask
  task automatic t_regs();
    rreg(ptq_pkg::OFS_CTRL, 32'h0000_0000);
    rreg(ptq_pkg::OFS_GLITCH, 32'h0000_0010);
    rreg(ptq_pkg::OFS_UPPER, 32'h0000_0020);
    rreg(ptq_pkg::OFS_LEVEL, 32'h0000_0080);
    rreg(8'h3C, 32'h0000_0000);
    rreg(ptq_pkg::OFS_STATUS, 32'h0000_0010);
    wreg(ptq_pkg::OFS_LOWER, 32'h0000_0040);
    rreg(ptq_pkg::OFS_LOWER, 32'h0000_0020);
    wreg(ptq_pkg::OFS_LOWER, 32'h0000_0010);
    $display("register test done");
  endtask
  task automatic t_pulses();
    run(13'h0000, 0, 8'h10, 8'hF0, 5, 0, 1);
    run(13'h0000, 0, 8'h10, 8'hF0, 30, 0, 0);
    run(13'h0080, 0, 8'h10, 8'hF0, 30, 0, 1);
    run(13'h0008, 0, 8'hF0, 8'h10, 5, 0, 1);
    run(13'h0010, 0, 8'h10, 8'hF0, 5, 0, 1);
    run(13'h0010, 0, 8'hF0, 8'h10, 5, 0, 1);
    run(13'h0001, 0, 8'h10, 8'h80, 5, 0, 1);
    run(13'h0001, 0, 8'h10, 8'hF0, 5, 0, 0);
    run(13'h0009, 0, 8'hF0, 8'h80, 5, 0, 1);
    run(13'h0011, 0, 8'hF0, 8'h80, 5, 0, 1);
    run(13'h0401, 0, 8'h10, 8'h80, 5, 0, 0);
    run(13'h0401, 0, 8'h10, 8'h80, 30, 0, 1);
    run(13'h0002, 0, 8'h10, 8'hF0, 20, 0, 1);
    run(13'h0002, 0, 8'h10, 8'hF0, 5, 0, 0);
    run(13'h0102, 0, 8'h10, 8'hF0, 5, 0, 1);
    run(13'h000A, 0, 8'hF0, 8'h10, 20, 0, 1);
    $display("glitch runt width test done");
  endtask
  task automatic t_timing();
    run(13'h0003, 0, 8'h10, 8'hF0, 4, 5, 1);
    run(13'h0203, 0, 8'h10, 8'hF0, 4, 5, 0);
    run(13'h0203, 0, 8'h10, 8'hF0, 4, 30, 1);
    run(13'h000B, 0, 8'hF0, 8'h10, 4, 5, 1);
    run(13'h0013, 0, 8'h10, 8'hF0, 4, 5, 2);
    run(13'h0004, 0, 8'h10, 8'hF0, 30, 0, 1);
    run(13'h0004, 0, 8'h10, 8'hF0, 10, 0, 0);
    run(13'h000C, 0, 8'hF0, 8'h10, 30, 0, 1);
    run(13'h0014, 0, 8'h10, 8'hF0, 30, 0, 2);
    run(13'h0044, 2, 8'h10, 8'hF0, 30, 0, 1);
    run(13'h0044, 0, 8'h10, 8'hF0, 30, 0, 0);
    $display("slew timeout source test done");
  endtask
  task automatic t_level();
    wreg(ptq_pkg::OFS_CTRL, 32'h0000_0800);
    repeat (2) @(posedge clk);
    #1 chk(level, 8'h60);
    wreg(ptq_pkg::OFS_CTRL, 32'h0000_1000);
    repeat (2) @(posedge clk);
    #1 chk(level, 8'h40);
    wreg(ptq_pkg::OFS_CTRL, 32'h0000_0005);
    wreg(ptq_pkg::OFS_LEVEL, 32'h0000_0090);
    repeat (2) @(posedge clk);
    #1 chk(level, 8'h90);
    hold(0, 8'h30, 4);
    wreg(ptq_pkg::OFS_CMD, 32'h0000_0001);
    repeat (10) begin
      hold(0, 8'hB0, 1);
      hold(0, 8'h30, 1);
    end
    repeat (4) @(posedge clk);
    #1 chk(level, 8'h70);
    wreg(ptq_pkg::OFS_LEVEL, 32'h0000_0080);
    wreg(ptq_pkg::OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1 chk(level, 8'h80);
    $display("level test done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs();
    t_pulses();
    t_timing();
    t_level();
    rreg(ptq_pkg::OFS_COUNT, trigs);
    print_verdict();
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
endmodule // testbench
